// *** rtl/cam_select_and_cascade.v ***
// Lookup device: selection, instruction entry, database access, cascade
`timescale 1ns/1ns
`include "cam_cascade_defs.vh"

module cam_select_and_cascade (
  input wire sys_clk, // System clock, 10 MHz
  input wire rst, // Synchronous reset, active high
  input wire cycle_strobe_n, // Cycle strobe, low during a cycle
  input wire write_n, // Low for write cycles
  input wire address_valid_n, // Low: direct address or execute
  input wire select_control_line, // Control word bit 12
  input wire [11:0] control_bus, // Control word bits 11..0
  input wire global_chip_select_n, // Broadcast chip select
  input wire local_chip_select_n, // Decoded chip select
  input wire output_enable_n, // Result bus enable request
  input wire [31:0] data_bus_in, // Data pins in
  output reg [31:0] data_bus_out, // Data pins out
  output reg data_bus_oe, // Data pins driven
  input wire validity_line_n_in, // Validity pin in
  output reg validity_line_n_out, // Validity pin out
  output reg validity_line_n_oe, // Validity pin driven
  input wire match_in_n, // Match chain in
  output reg match_out_n, // Match chain out
  output reg multi_match_n_out, // Open-drain level, always low
  output reg multi_match_n_oe, // Open-drain pull-down
  input wire full_in_n, // Full chain in
  output reg full_out_n, // Full chain out
  output reg [16:0] result_address_bus_out, // Page and active address
  output reg result_address_bus_oe // Result bus driven
);

  // ==========================================================
  // Registers and cycle state
  reg strobe_d_r;
  reg [31:0] dev_sel_r;
  reg [31:0] instr_r;
  reg [31:0] cfg_r;
  reg [31:0] addr_r;
  reg [`DB_DW-1:0] comparand_r;
  reg [12:0] ctl_r;
  reg write_r;
  reg direct_r;
  reg ir_load_r;
  reg [`ACT_AW-1:0] act_r;
  reg [1:0] act_type_r;
  wire match_l_r;
  wire multi_l_r;
  wire [`ACT_AW-1:0] act_addr;
  reg full_l_r;
  reg [`ACT_AW-1:0] act_nxt;
  reg [1:0] act_type_nxt;
  wire fall;
  wire rise;
  wire sw_mode;
  wire selected_r;
  wire [3:0] page;
  wire [5:0] op;
  wire [12:0] ctl_now;
  wire [`DB_DW-1:0] rd_data;
  wire rd_empty;
  wire hit_r;
  wire multi_r;
  wire [`DB_AW-1:0] hit_addr_r;
  wire full;
  wire [`DB_AW-1:0] free_addr;
  reg [`DB_AW-1:0] mem_addr;
  reg wr_en;
  reg vld_en;
  reg cmp_en;
  reg [31:0] status;

  assign fall = strobe_d_r & ~cycle_strobe_n;
  assign rise = ~strobe_d_r & cycle_strobe_n;
  assign sw_mode = |cfg_r[`FR_MODE_MSB:`FR_MODE_LSB];
  assign page = cfg_r[`FR_PAGE_MSB:0];
  // Software mode takes its control word from the instruction register
  assign ctl_now = sw_mode ? instr_r[12:0] : {select_control_line, control_bus};
  assign op = ctl_r[`OP_MSB:0];
  // Local flags are the array's compare registers, so no reach into its internals
  assign match_l_r = hit_r;
  assign multi_l_r = multi_r;
  // A match result points at the latched best address
  assign act_addr = (act_type_r == `TYPE_MATCH) ? {1'b0, hit_addr_r} : act_r;

  // Chain gating shared by read drive and write execution
  function chain_ok;
    input [5:0] code;
    input mi_n;
    input hit;
    input fi_n;
    input is_full;
    begin
      case (code)
        `OP_HPM, `OP_SR: chain_ok = mi_n & hit;
        `OP_NFA: chain_ok = ~fi_n & ~is_full;
        default: chain_ok = 1'b1;
      endcase
    end
  endfunction

  cam_select u_select (
    .sys_clk(sys_clk),
    .rst(rst),
    .sample(fall),
    .global_chip_select_n(global_chip_select_n),
    .local_chip_select_n(local_chip_select_n),
    .dev_sel(dev_sel_r),
    .page_address(page),
    .selected_r(selected_r)
  );

  cam_array u_array (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(wr_en),
    .wr_addr(mem_addr),
    .wr_data(comparand_r),
    .wr_empty(validity_line_n_in),
    .vld_en(vld_en),
    .vld_addr(addr_r[`DB_AW-1:0]),
    .vld_empty(op == `OP_VCLR),
    .cmp_en(cmp_en),
    .cmp_data(comparand_r),
    .rd_addr(mem_addr),
    .rd_data(rd_data),
    .rd_empty(rd_empty),
    .hit_r(hit_r),
    .multi_r(multi_r),
    .hit_addr_r(hit_addr_r),
    .full(full),
    .free_addr(free_addr)
  );

  // ==========================================================
  // Database address and write strobes
  always @* begin
    if (direct_r) begin
      mem_addr = ctl_r[`DB_AW-1:0];
    end else begin
      case (op)
        `OP_NFA: mem_addr = free_addr;
        `OP_HPM: mem_addr = hit_addr_r;
        default: mem_addr = addr_r[`DB_AW-1:0];
      endcase
    end
  end

  always @* begin
    wr_en = 1'b0;
    vld_en = 1'b0;
    cmp_en = 1'b0;
    if (rise && selected_r && !ir_load_r) begin
      if (direct_r) begin
        wr_en = ~write_r;
      end else begin
        case (op)
          `OP_NFA, `OP_HPM: wr_en = ~write_r & chain_ok(op, match_in_n, match_l_r, full_in_n, full_l_r);
          `OP_MAR: wr_en = ~write_r;
          `OP_CMP: cmp_en = 1'b1;
          `OP_VSET, `OP_VCLR: vld_en = 1'b1;
          default: wr_en = 1'b0;
        endcase
      end
    end
  end

  always @* begin
    status = 32'h0000_0000;
    status[`SR_MF_BIT] = ~match_l_r;
    status[`SR_MM_BIT] = ~multi_l_r;
    status[`SR_FF_BIT] = ~full_l_r;
    status[`SR_TYPE_MSB:`SR_TYPE_LSB] = act_type_r;
    status[`SR_PAGE_LSB+3:`SR_PAGE_LSB] = page;
    status[`ACT_AW-1:0] = act_addr;
  end

  // Memory access moves the active address, compare points it at the match address, other cycles keep it
  always @* begin
    act_nxt = act_r;
    act_type_nxt = act_type_r;
    if (rise && selected_r && !ir_load_r) begin
      if (direct_r || op == `OP_MAR || op == `OP_NFA || op == `OP_HPM) begin
        act_nxt = {1'b0, mem_addr};
        act_type_nxt = `TYPE_MEM;
      end
      if (op == `OP_CMP && !direct_r) begin
        act_nxt = act_r;
        act_type_nxt = `TYPE_MATCH;
      end
    end
  end

  // ==========================================================
  // Cycle capture and register writes
  always @(posedge sys_clk) begin
    if (rst) begin
      strobe_d_r <= 1'b1;
      ctl_r <= 13'h0000;
      write_r <= 1'b1;
      direct_r <= 1'b0;
      ir_load_r <= 1'b0;
    end else begin
      strobe_d_r <= cycle_strobe_n;
      if (fall) begin
        write_r <= write_n;
        direct_r <= ~address_valid_n & ~sw_mode;
        ir_load_r <= ~address_valid_n ? 1'b0 : sw_mode;
        ctl_r <= ~address_valid_n & ~sw_mode ? {select_control_line, control_bus} : ctl_now;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      dev_sel_r <= `DS_RST;
      instr_r <= 32'h0000_0000;
      cfg_r <= `FR_RST;
      addr_r <= 32'h0000_0000;
      comparand_r <= {`DB_DW{1'b0}};
    end else if (rise && selected_r && !write_r) begin
      if (ir_load_r) begin
        instr_r <= data_bus_in;
      end else if (!direct_r) begin
        case (op)
          `OP_DS: dev_sel_r <= data_bus_in;
          `OP_FR: cfg_r <= data_bus_in;
          `OP_AR: addr_r <= data_bus_in;
          `OP_CRL: comparand_r[31:0] <= data_bus_in;
          `OP_CRH: comparand_r[63:32] <= data_bus_in;
          default: addr_r <= addr_r;
        endcase
      end
    end
  end

  // ==========================================================
  // Local flags, frozen until the strobe rises
  always @(posedge sys_clk) begin
    if (rst) begin
      full_l_r <= 1'b0;
      act_r <= {`ACT_AW{1'b0}};
      act_type_r <= `TYPE_RESET;
    end else begin
      act_r <= act_nxt;
      act_type_r <= act_type_nxt;
      // Full may move only outside a cycle or at its end
      if (cycle_strobe_n) begin
        full_l_r <= full;
      end
    end
  end

  // ==========================================================
  // Daisy chains; one flop of latency keeps outputs registered
  always @(posedge sys_clk) begin
    if (rst) begin
      match_out_n <= 1'b1;
      multi_match_n_out <= 1'b0;
      multi_match_n_oe <= 1'b0;
      full_out_n <= 1'b1;
    end else begin
      match_out_n <= ~(~match_in_n | match_l_r);
      multi_match_n_out <= 1'b0;
      multi_match_n_oe <= (match_in_n & multi_l_r) | (~match_in_n & match_l_r & ~multi_l_r);
      full_out_n <= ~(~full_in_n & full_l_r);
    end
  end

  // ==========================================================
  // Bus drive: reads answer from strobe fall until strobe rise
  always @(posedge sys_clk) begin
    if (rst) begin
      data_bus_out <= 32'h0000_0000;
      data_bus_oe <= 1'b0;
      validity_line_n_out <= 1'b1;
      validity_line_n_oe <= 1'b0;
    end else if (fall && write_n && (~global_chip_select_n | ~local_chip_select_n
        | (~dev_sel_r[`DS_EN_BIT] & (dev_sel_r[`DS_PAGE_MSB:0] == page)))) begin
      // Decode here uses the live pins since the sampled select lands a cycle later
      data_bus_oe <= 1'b0;
      validity_line_n_oe <= 1'b0;
    end else if (strobe_d_r == 1'b0 && selected_r && write_r && !ir_load_r && !cycle_strobe_n
        && !data_bus_oe) begin
      data_bus_oe <= direct_r | chain_ok(op, match_in_n, match_l_r, full_in_n, full_l_r);
      // Validity only accompanies a data drive, never a refused one
      validity_line_n_oe <= (direct_r | op == `OP_MAR | op == `OP_HPM)
        & (direct_r | chain_ok(op, match_in_n, match_l_r, full_in_n, full_l_r));
      validity_line_n_out <= rd_empty;
      if (direct_r) begin
        data_bus_out <= rd_data[31:0];
      end else begin
        case (op)
          `OP_SR: data_bus_out <= status;
          `OP_NFA: data_bus_out <= {12'h000, page, 3'h0, 1'b0, free_addr};
          `OP_FR: data_bus_out <= cfg_r;
          `OP_DS: data_bus_out <= dev_sel_r;
          `OP_AR: data_bus_out <= addr_r;
          `OP_MAR, `OP_HPM: data_bus_out <= ctl_r[`OP_HALF_BIT] ? rd_data[63:32] : rd_data[31:0];
          default: data_bus_out <= instr_r;
        endcase
      end
    end else if (cycle_strobe_n) begin
      data_bus_oe <= 1'b0;
      validity_line_n_oe <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      result_address_bus_out <= 17'h00000;
      result_address_bus_oe <= 1'b0;
    end else begin
      result_address_bus_out <= {page, act_addr};
      result_address_bus_oe <= ~output_enable_n & (act_type_r == `TYPE_MEM
        | (act_type_r == `TYPE_MATCH & match_in_n & match_l_r));
    end
  end

endmodule // cam_select_and_cascade

// *** rtl/cam_cascade_defs.vh ***
// Constants for the lookup device select, database and cascade logic
`ifndef CAM_CASCADE_DEFS_VH
`define CAM_CASCADE_DEFS_VH

// ==========================================================
// Database organisation
`define DB_DEPTH 4096
`define DB_AW 12
`define DB_DW 64
`define ACT_AW 13

// ==========================================================
// Control code (low six bits of the 13-bit control word)
`define OP_MSB 5
`define OP_NOP 6'h03
`define OP_AR 6'h04
`define OP_FR 6'h06
`define OP_DS 6'h08
`define OP_CRL 6'h0a
`define OP_CRH 6'h0b
`define OP_CMP 6'h10
`define OP_NFA 6'h12
`define OP_HPM 6'h14
`define OP_MAR 6'h16
`define OP_SR 6'h18
`define OP_VSET 6'h1a
`define OP_VCLR 6'h1c
`define OP_HALF_BIT 6

// ==========================================================
// Software device select register fields
`define DS_EN_BIT 8
`define DS_PAGE_MSB 3
`define DS_RST 32'h0000_0100

// ==========================================================
// Configuration register fields
`define FR_MODE_MSB 27
`define FR_MODE_LSB 26
`define FR_PAGE_MSB 3
`define FR_RST 32'h0400_0000

// ==========================================================
// Status register fields
`define SR_MF_BIT 30
`define SR_MM_BIT 29
`define SR_FF_BIT 28
`define SR_TYPE_MSB 25
`define SR_TYPE_LSB 24
`define SR_PAGE_LSB 16
`define TYPE_RESET 2'h0
`define TYPE_MATCH 2'h1
`define TYPE_MEM 2'h2

`endif

// *** rtl/cam_select.v ***
// Device selection from chip selects and software select register
`timescale 1ns/1ns
`include "cam_cascade_defs.vh"

module cam_select (
  input wire sys_clk, // System clock
  input wire rst, // Synchronous reset
  input wire sample, // Strobe falling edge
  input wire global_chip_select_n, // Broadcast select
  input wire local_chip_select_n, // Decoded select
  input wire [31:0] dev_sel, // Software select register
  input wire [3:0] page_address, // Own page
  output reg selected_r // Selection for this cycle
);

  function soft_hit;
    input [31:0] ds;
    input [3:0] pg;
    begin
      soft_hit = ~ds[`DS_EN_BIT] && (ds[`DS_PAGE_MSB:0] == pg);
    end
  endfunction

  always @(posedge sys_clk) begin
    if (rst) begin
      selected_r <= 1'b0;
    end else if (sample) begin
      selected_r <= ~global_chip_select_n | ~local_chip_select_n | soft_hit(dev_sel, page_address);
    end
  end

endmodule // cam_select

// *** rtl/cam_array.v ***
// Address database with validity bits, compare and next-free search
`timescale 1ns/1ns
`include "cam_cascade_defs.vh"

module cam_array (
  input wire sys_clk, // System clock
  input wire rst, // Synchronous reset
  input wire wr_en, // Entry write
  input wire [`DB_AW-1:0] wr_addr, // Entry write address
  input wire [`DB_DW-1:0] wr_data, // Entry write data
  input wire wr_empty, // Validity for written entry
  input wire vld_en, // Validity-only update
  input wire [`DB_AW-1:0] vld_addr, // Validity update address
  input wire vld_empty, // Validity value
  input wire cmp_en, // Compare now
  input wire [`DB_DW-1:0] cmp_data, // Comparand
  input wire [`DB_AW-1:0] rd_addr, // Read address
  output wire [`DB_DW-1:0] rd_data, // Read data
  output wire rd_empty, // Read validity
  output reg hit_r, // Any match
  output reg multi_r, // More than one match
  output reg [`DB_AW-1:0] hit_addr_r, // Best match address
  output reg full, // No empty entry
  output reg [`DB_AW-1:0] free_addr // Best empty address
);

  reg [`DB_DW-1:0] mem [0:`DB_DEPTH-1];
  reg [`DB_DEPTH-1:0] empty_r;
  reg hit;
  reg multi;
  reg [`DB_AW-1:0] hit_addr;
  integer i;

  assign rd_data = mem[rd_addr];
  assign rd_empty = empty_r[rd_addr];

  // Scan downward so the lowest index wins the priority
  always @* begin
    hit = 1'b0;
    multi = 1'b0;
    hit_addr = {`DB_AW{1'b0}};
    full = 1'b1;
    free_addr = {`DB_AW{1'b0}};
    for (i = `DB_DEPTH - 1; i >= 0; i = i - 1) begin
      if (!empty_r[i] && mem[i] == cmp_data) begin
        multi = multi | hit;
        hit = 1'b1;
        hit_addr = i[`DB_AW-1:0];
      end
      if (empty_r[i]) begin
        full = 1'b0;
        free_addr = i[`DB_AW-1:0];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      empty_r <= {`DB_DEPTH{1'b1}};
    end else if (wr_en) begin
      empty_r[wr_addr] <= wr_empty;
    end else if (vld_en) begin
      empty_r[vld_addr] <= vld_empty;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      hit_r <= 1'b0;
      multi_r <= 1'b0;
      hit_addr_r <= {`DB_AW{1'b0}};
    end else if (cmp_en) begin
      hit_r <= hit;
      multi_r <= multi;
      hit_addr_r <= hit_addr;
    end
  end

endmodule // cam_array

// *** testbench/cam_cascade_properties.sv ***
// Assertions on the lookup device read timing and cascade chain ports
`timescale 1ns/1ns
module cam_cascade_properties (
  input wire sys_clk, // Clock
  input wire rst, // Reset
  input wire cycle_strobe_n, // Strobe
  input wire write_n, // Write
  input wire output_enable_n, // Result request
  input wire data_bus_oe, // Data driven
  input wire validity_line_n_oe, // Validity driven
  input wire match_in_n, // Chain in
  input wire match_out_n, // Chain out
  input wire multi_match_n_oe, // Pull-down
  input wire full_in_n, // Chain in
  input wire full_out_n, // Chain out
  input wire result_address_bus_oe // Result driven
);
  // ==========
  // Clocking
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  // Sequences
  sequence s_held_low;
    !cycle_strobe_n ##1 (!cycle_strobe_n && $stable(match_in_n));
  endsequence
  sequence s_read_over;
    data_bus_oe && cycle_strobe_n;
  endsequence
  // ==========
  // Properties
  property p_full_low; !full_out_n |-> $past(!full_in_n); endproperty
  property p_full_high; full_in_n |=> full_out_n; endproperty
  property p_match_low; !match_in_n |=> !match_out_n; endproperty
  property p_ra_oe; result_address_bus_oe |-> $past(!output_enable_n); endproperty
  property p_read_lat;
    $rose(data_bus_oe) |-> $past(!cycle_strobe_n) && $past(!cycle_strobe_n, 2) && $past(cycle_strobe_n, 3)
      && $past(write_n, 2);
  endproperty
  property p_read_end; s_read_over |=> !data_bus_oe; endproperty
  property p_vld_oe; validity_line_n_oe |-> data_bus_oe; endproperty
  // Match chain outputs may move only after a strobe rise while match in holds; full out is not checked
  property p_chain_hold; s_held_low |=> $stable(match_out_n) && $stable(multi_match_n_oe); endproperty
  a_full_low: assert property (p_full_low) else $error("full out low without full in low");
  a_full_high: assert property (p_full_high) else $error("full out not high");
  a_match_low: assert property (p_match_low) else $error("match out not forced low");
  a_ra_oe: assert property (p_ra_oe) else $error("result bus driven unrequested");
  a_read_lat: assert property (p_read_lat) else $error("read drive at wrong time");
  a_read_end: assert property (p_read_end) else $error("data drive not released");
  a_vld_oe: assert property (p_vld_oe) else $error("validity driven alone");
  a_chain_hold: assert property (p_chain_hold) else $error("chain moved inside cycle");
endmodule // cam_cascade_properties

bind cam_select_and_cascade cam_cascade_properties i_props (.sys_clk, .rst, .cycle_strobe_n, .write_n,
  .output_enable_n, .data_bus_oe, .validity_line_n_oe, .match_in_n, .match_out_n, .multi_match_n_oe,
  .full_in_n, .full_out_n, .result_address_bus_oe);

// *** testbench/cam_neighbour.sv ***
// Model of the neighbouring devices on the match and full chains
`timescale 1ns/1ns
module cam_neighbour (
  input wire sys_clk, // Clock
  input wire upstream_hit, // Higher device matched
  input wire upstream_room, // Higher device has room
  input wire [3:0] lag, // Ripple cycles
  output reg match_in_n, // To chain input
  output reg full_in_n // To chain input
);
  reg [3:0] wait_r;
  // ==========
  // Chain ripple
  // Head of chain: nothing matched or free above
  initial begin
    match_in_n = 1'h1;
    full_in_n = 1'h0;
    wait_r = 4'h0;
  end
  // Old level kept until the ripple has passed
  always @(posedge sys_clk) begin
    if (match_in_n == ~upstream_hit && full_in_n == upstream_room) begin
      wait_r <= lag;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else begin
      match_in_n <= ~upstream_hit;
      full_in_n <= upstream_room;
    end
  end
endmodule // cam_neighbour

// *** testbench/testbench.sv ***
// Self-checking bench for the lookup device select and cascade block
`timescale 1ns/1ns
`include "cam_cascade_defs.vh"
module testbench;
  logic sys_clk, rst, cycle_strobe_n, write_n, address_valid_n, select_control_line;
  logic global_chip_select_n, local_chip_select_n, output_enable_n, host_vb, upstream_hit, upstream_room;
  logic data_bus_oe, validity_line_n_out, validity_line_n_oe, match_out_n, match_in_n, full_in_n;
  logic multi_match_n_out, multi_match_n_oe, full_out_n, result_address_bus_oe, rd_seen, rd_vld;
  logic [11:0] control_bus;
  logic [31:0] host_dq, data_bus_out, rd_data;
  logic [16:0] result_address_bus_out;
  logic [3:0] lag;
  logic [31:0] ds_val [3] = '{32'h0000_0005, 32'h0000_0006, 32'h0000_0105};
  logic ds_hit [3] = '{1'h1, 1'h0, 1'h0};
  logic [12:0] ent_addr [3] = '{13'h0000, 13'h0003, 13'h0001};
  logic ent_vb [3] = '{1'h0, 1'h0, 1'h1};
  int mismatches, tests_run;
  wire [31:0] dq = data_bus_oe ? data_bus_out : host_dq;
  wire vline = validity_line_n_oe ? validity_line_n_out : host_vb;
  wire mm_wire = multi_match_n_oe ? multi_match_n_out : 1'h1; // Pull-up

  cam_select_and_cascade i_cam_select_and_cascade (.sys_clk, .rst, .cycle_strobe_n, .write_n, .address_valid_n,
    .select_control_line, .control_bus, .global_chip_select_n, .local_chip_select_n, .output_enable_n,
    .data_bus_in(dq), .data_bus_out, .data_bus_oe, .validity_line_n_in(vline), .validity_line_n_out,
    .validity_line_n_oe, .match_in_n, .match_out_n, .multi_match_n_out, .multi_match_n_oe, .full_in_n,
    .full_out_n, .result_address_bus_out, .result_address_bus_oe);
  cam_neighbour i_cam_neighbour (.sys_clk, .upstream_hit, .upstream_room, .lag, .match_in_n, .full_in_n);

  // ==========
  // Checks and bus cycles
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One strobe cycle; cs is {global, local}, active low
  task automatic cyc(input logic wr, input logic av, input logic [12:0] ctl, input logic [1:0] cs,
                     input logic [31:0] d, input logic vb);
    @(posedge sys_clk);
    cycle_strobe_n <= 1'h0;
    write_n <= ~wr;
    address_valid_n <= av;
    {select_control_line, control_bus} <= ctl;
    {global_chip_select_n, local_chip_select_n} <= cs;
    // Released bus shows the inverse, not a stale copy
    host_dq <= wr ? d : ~host_dq;
    host_vb <= vb;
    rd_seen = 1'h0;
    rd_data = 32'hx;
    rd_vld = 1'hx;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      if (data_bus_oe === 1'h1) begin
        rd_seen = 1'h1;
        rd_data = data_bus_out;
        rd_vld = validity_line_n_out;
      end
    end
    @(posedge sys_clk);
    cycle_strobe_n <= 1'h1;
    {global_chip_select_n, local_chip_select_n} <= 2'h3;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [12:0] ctl, input logic av, input logic [31:0] d, input logic vb);
    cyc(1'h1, av, ctl, 2'h1, d, vb);
  endtask
  task automatic rd(input logic [12:0] ctl, input logic av, input logic [1:0] cs, input logic s,
                    input logic [31:0] d);
    cyc(1'h0, av, ctl, cs, 32'h0, 1'h0);
    chk1(rd_seen, s);
    if (s) chk32(rd_data, d);
  endtask
  // Chain ripple needs time before results are trusted
  task automatic chain(input logic hit, input logic room, input logic oe_n);
    @(posedge sys_clk);
    upstream_hit <= hit;
    upstream_room <= room;
    output_enable_n <= oe_n;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========
  // Clock, watchdog, tests
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #6_000_000;
    mismatches++;
    wrap_up;
  end
  initial begin
    rst <= 1'h1;
    cycle_strobe_n <= 1'h1;
    write_n <= 1'h1;
    address_valid_n <= 1'h1;
    {select_control_line, control_bus} <= 13'h0;
    {global_chip_select_n, local_chip_select_n} <= 2'h3;
    output_enable_n <= 1'h1;
    host_dq <= 32'h0;
    host_vb <= 1'h0;
    upstream_hit <= 1'h0;
    upstream_room <= 1'h0;
    lag <= 4'h3;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk1(data_bus_oe, 1'h0);
    chk1(match_out_n, 1'h1);
    cyc(1'h1, 1'h1, 13'h0, 2'h1, 32'h0000_0006, 1'h0);
    cyc(1'h1, 1'h0, 13'h0, 2'h1, 32'h0000_0005, 1'h0);
    rd(13'h0006, 1'h1, 2'h2, 1'h1, 32'h0000_0005);
    rd(13'h0006, 1'h1, 2'h1, 1'h1, 32'h0000_0005);
    foreach (ds_val[i]) begin
      wr(13'h0008, 1'h1, ds_val[i], 1'h0);
      rd(13'h0006, 1'h1, 2'h3, ds_hit[i], 32'h0000_0005);
    end
    wr(13'h000a, 1'h1, 32'h3333_4444, 1'h0);
    wr(13'h000b, 1'h1, 32'h1111_2222, 1'h0);
    foreach (ent_addr[i]) wr(ent_addr[i], 1'h0, 32'h0, ent_vb[i]);
    rd(13'h0000, 1'h0, 2'h2, 1'h1, 32'h3333_4444);
    chk1(rd_vld, 1'h0);
    rd(13'h0001, 1'h0, 2'h2, 1'h1, 32'h3333_4444);
    chk1(rd_vld, 1'h1);
    rd(13'h0012, 1'h1, 2'h1, 1'h1, 32'h0005_0001);
    chain(1'h0, 1'h1, 1'h1);
    rd(13'h0012, 1'h1, 2'h1, 1'h0, 32'h0);
    chain(1'h0, 1'h0, 1'h1);
    wr(13'h0010, 1'h1, 32'h0, 1'h0);
    wr(13'h000a, 1'h1, 32'h0, 1'h0);
    chain(1'h0, 1'h0, 1'h0);
    chk1(match_out_n, 1'h0);
    chk1(mm_wire, 1'h0);
    chk1(result_address_bus_oe, 1'h1);
    chk32({15'h0, result_address_bus_out}, 32'h0000_a000);
    rd(13'h0018, 1'h1, 2'h1, 1'h1, 32'h1105_0000);
    chain(1'h0, 1'h0, 1'h1);
    wr(13'h000a, 1'h1, 32'h3333_4444, 1'h0);
    wr(13'h0004, 1'h1, 32'h0, 1'h0);
    wr(13'h001c, 1'h1, 32'h0, 1'h0);
    wr(13'h0004, 1'h1, 32'h3, 1'h0);
    rd(13'h0016, 1'h1, 2'h2, 1'h1, 32'h3333_4444);
    wr(13'h0010, 1'h1, 32'h0, 1'h0);
    chain(1'h0, 1'h0, 1'h1);
    rd(13'h0018, 1'h1, 2'h1, 1'h1, 32'h3105_0003);
    chk1(mm_wire, 1'h1);
    rd(13'h0014, 1'h1, 2'h1, 1'h1, 32'h3333_4444);
    rd(13'h0054, 1'h1, 2'h1, 1'h1, 32'h1111_2222);
    chain(1'h1, 1'h0, 1'h1);
    chk1(match_out_n, 1'h0);
    chk1(mm_wire, 1'h0);
    rd(13'h0018, 1'h1, 2'h1, 1'h0, 32'h0);
    rd(13'h0014, 1'h1, 2'h1, 1'h0, 32'h0);
    rd(13'h0003, 1'h0, 2'h2, 1'h1, 32'h3333_4444);
    wr(13'h0012, 1'h1, 32'h0, 1'h0);
    rd(13'h0012, 1'h1, 2'h1, 1'h1, 32'h0005_0001);
    chain(1'h0, 1'h0, 1'h1);
    for (int a = 0; a < `DB_DEPTH; a++) wr(a[12:0], 1'h0, 32'h0, 1'h0);
    chain(1'h0, 1'h0, 1'h1);
    chk1(full_out_n, 1'h0);
    rd(13'h0012, 1'h1, 2'h1, 1'h0, 32'h0);
    chain(1'h0, 1'h1, 1'h1);
    chk1(full_out_n, 1'h1);
    wrap_up;
  end
endmodule // testbench
